// ==== nvsrc_ctrl.sv ====
// Purpose: Host controller driving an 8K x 8 nvsram over its asynchronous pins
// Assumes: 20 MHz clock; read data pins arrive from outside and are synchronised
// Notes:   Pin levels are registered, so they lag the state by one cycle
`timescale 1ns/1ps
`include "nvsrc_defines.svh"

module nvsrc_ctrl
    import nvsrc_pkg::*;
#(
    parameter logic [`NVSRC_CNT_W-1:0] STORE_WAIT_CYC = `NVSRC_CNT_W'(`NVSRC_STORE_CYC)
) (
    input  wire logic                      clk_i,
    input  wire logic                      rstn_i,
    input  wire logic                      cmd_valid_i,
    output logic                           cmd_ready_o,
    input  wire nvsrc_pkg::nvsrc_cmd_t     cmd_i,
    output logic                           rsp_valid_o,
    output logic [`NVSRC_DATA_W-1:0]       rsp_rdata_o,
    output nvsrc_pkg::nvsrc_pins_t         pins_o,
    input  wire logic [`NVSRC_DATA_W-1:0]  data_pins_i
);

    import nvsrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    nvsrc_state_t                state_q;
    nvsrc_state_t                state_d;
    nvsrc_op_t                   op_q;
    logic [`NVSRC_ADDR_W-1:0]    addr_q;
    logic [`NVSRC_DATA_W-1:0]    wdata_q;
    logic [`NVSRC_IDX_W-1:0]     idx_q;
    logic [`NVSRC_IDX_W-1:0]     idx_d;
    logic [`NVSRC_DATA_W-1:0]    dq_s1_q;
    logic [`NVSRC_DATA_W-1:0]    dq_s2_q;
    logic [`NVSRC_DATA_W-1:0]    rdata_q;
    logic                        rsp_q;
    logic                        rsp_d;
    nvsrc_pins_t                 pins_q;
    nvsrc_pins_t                 pins_d;
    logic                        tmr_load;
    logic [`NVSRC_CNT_W-1:0]     tmr_value;
    logic                        tmr_done;
    logic                        take;
    logic                        in_idle;
    logic                        in_setup;
    logic                        in_sel;
    logic                        in_rel;
    logic                        in_wait;
    logic                        active;
    logic                        is_rd;
    logic                        is_wr;
    logic                        is_rce;
    logic                        is_roe;
    logic                        is_rec;
    logic                        is_sw;
    logic                        seq_last;
    logic [`NVSRC_ADDR_W-1:0]    seq_addr;
    logic [`NVSRC_ADDR_W-1:0]    last_addr;
    logic [`NVSRC_CNT_W-1:0]     sel_cyc;
    logic [`NVSRC_CNT_W-1:0]     nv_cyc;

    ////////////////////////////////////////////////////////////////////////////
    // State and operation decode
    assign in_idle  = (state_q == NVSRC_ST_IDLE);
    assign in_setup = (state_q == NVSRC_ST_SETUP);
    assign in_sel   = (state_q == NVSRC_ST_SELECT);
    assign in_rel   = (state_q == NVSRC_ST_RELEASE);
    assign in_wait  = (state_q == NVSRC_ST_WAIT);
    assign active   = in_setup | in_sel;
    assign is_rd    = (op_q == NVSRC_OP_READ);
    assign is_wr    = (op_q == NVSRC_OP_WRITE);
    assign is_rce   = (op_q == NVSRC_OP_RECALL_CE);
    assign is_roe   = (op_q == NVSRC_OP_RECALL_OE);
    assign is_rec   = is_rce | is_roe;
    assign is_sw    = (op_q == NVSRC_OP_SW_STORE) | (op_q == NVSRC_OP_SW_RECALL);
    assign seq_last = (idx_q == `NVSRC_SEQ_LAST);

    assign cmd_ready_o = in_idle;
    assign take        = cmd_valid_i & in_idle;

    ////////////////////////////////////////////////////////////////////////////
    // Sequence address selection
    // store or recall final address
    assign last_addr = (op_q == NVSRC_OP_SW_RECALL) ? `NVSRC_SEQ_RECALL_ADDR
                                                    : `NVSRC_SEQ_STORE_ADDR;
    assign seq_addr = (idx_q == `NVSRC_SEQ_FIRST) ? `NVSRC_SEQ_ADDR0 :
                      (idx_q == `NVSRC_SEQ_IDX1)  ? `NVSRC_SEQ_ADDR1 :
                      (idx_q == `NVSRC_SEQ_IDX2)  ? `NVSRC_SEQ_ADDR2 :
                      (idx_q == `NVSRC_SEQ_IDX3)  ? `NVSRC_SEQ_ADDR3 :
                      (idx_q == `NVSRC_SEQ_IDX4)  ? `NVSRC_SEQ_ADDR4 : last_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Phase lengths
    // select pulse length
    assign sel_cyc = is_rec ? `NVSRC_CNT_W'(`NVSRC_RECALL_INIT_CYC) :
                     is_rd  ? `NVSRC_CNT_W'(`NVSRC_READ_CYC) :
                              `NVSRC_CNT_W'(`NVSRC_SELECT_CYC);
    assign nv_cyc  = (op_q == NVSRC_OP_SW_STORE) ? STORE_WAIT_CYC
                                                 : `NVSRC_CNT_W'(`NVSRC_RECALL_CYC);
    assign tmr_load  = in_setup | (in_rel & (is_rec | (is_sw & seq_last)));
    assign tmr_value = in_setup ? sel_cyc : nv_cyc;

    nvsrc_timer #(
        .W       (`NVSRC_CNT_W)
    ) u_timer (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .load_i  (tmr_load),
        .value_i (tmr_value),
        .done_o  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        rsp_d   = 1'b0;
        case (state_q)
            NVSRC_ST_IDLE: begin
                if (take) begin
                    state_d = NVSRC_ST_SETUP;
                    idx_d   = `NVSRC_SEQ_FIRST;
                end
            end
            NVSRC_ST_SETUP: begin
                state_d = NVSRC_ST_SELECT;
            end
            NVSRC_ST_SELECT: begin
                if (tmr_done) begin
                    state_d = NVSRC_ST_RELEASE;
                end
            end
            NVSRC_ST_RELEASE: begin
                if (is_rec || (is_sw && seq_last)) begin
                    state_d = NVSRC_ST_WAIT;
                end else if (is_sw) begin
                    state_d = NVSRC_ST_SETUP;
                    idx_d   = `NVSRC_IDX_W'(idx_q + `NVSRC_SEQ_IDX1);
                end else begin
                    state_d = NVSRC_ST_IDLE;
                    rsp_d   = 1'b1;
                end
            end
            NVSRC_ST_WAIT: begin
                if (tmr_done) begin
                    state_d = NVSRC_ST_IDLE;
                    rsp_d   = 1'b1;
                end
            end
            default: begin
                state_d = NVSRC_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin levels for the current phase
    // address from setup on
    assign pins_d.address_pins = is_sw ? seq_addr : addr_q;
    assign pins_d.chip_enable_n = ~((in_sel & ~is_roe) | (active & is_roe));
    assign pins_d.write_enable_n = ~(is_wr & active);
    assign pins_d.output_enable_n = ~((is_rd & active) | (is_rce & active)
                                      | (is_roe & in_sel));
    assign pins_d.nonvolatile_trigger_n = ~(is_rec & active);
    assign pins_d.data_pins = wdata_q;
    assign pins_d.data_pins_oe = is_wr & (active | in_rel);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= NVSRC_ST_IDLE;
            idx_q   <= `NVSRC_SEQ_FIRST;
            rsp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
            rsp_q   <= rsp_d;
        end
    end

    // Command capture
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_q    <= NVSRC_OP_READ;
            addr_q  <= '0;
            wdata_q <= '0;
        end else if (take) begin
            op_q    <= cmd_i.op;
            addr_q  <= cmd_i.addr;
            wdata_q <= cmd_i.wdata;
        end
    end

    // Registered pins, idle levels deselected
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_q <= '{chip_enable_n: 1'b1, write_enable_n: 1'b1,
                        output_enable_n: 1'b1, nonvolatile_trigger_n: 1'b1,
                        address_pins: '0, data_pins: '0, data_pins_oe: 1'b0};
        end else begin
            pins_q <= pins_d;
        end
    end

    // Two-stage synchroniser on the data pins
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= data_pins_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= '0;
        end else if (in_sel && tmr_done && is_rd) begin
            rdata_q <= dq_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign pins_o      = pins_q;
    assign rsp_valid_o = rsp_q;
    assign rsp_rdata_o = rdata_q;

endmodule

// ==== nvsrc_ctrl_properties.sv ====
// Purpose: Pin-order assertions for the nvsram controller
// Assumes: Sees only the ports of nvsrc_ctrl
// Notes:   Recall span is counted from the trigger fall
`timescale 1ns/1ps
`include "nvsrc_defines.svh"

module nvsrc_ctrl_properties
    import nvsrc_pkg::*;
#(
    parameter logic [`NVSRC_CNT_W-1:0] STORE_WAIT_CYC = 18'h00014
) (
    input wire logic                     clk_i,
    input wire logic                     rstn_i,
    input wire logic                     cmd_valid_i,
    input wire logic                     cmd_ready_o,
    input wire nvsrc_pkg::nvsrc_cmd_t    cmd_i,
    input wire logic                     rsp_valid_o,
    input wire logic [`NVSRC_DATA_W-1:0] rsp_rdata_o,
    input wire nvsrc_pkg::nvsrc_pins_t   pins_o,
    input wire logic [`NVSRC_DATA_W-1:0] data_pins_i
);
    logic       trig_q;
    logic [8:0] span_q;
    logic [8:0] span_d;
    // Pin aliases
    wire logic        ce_n  = pins_o.chip_enable_n;
    wire logic        we_n  = pins_o.write_enable_n;
    wire logic        oe_n  = pins_o.output_enable_n;
    wire logic        tr_n  = pins_o.nonvolatile_trigger_n;
    wire logic [12:0] addr  = pins_o.address_pins;
    wire logic        rc_st = !ce_n && !oe_n && we_n && !tr_n;
    // Recall span, initiation cycle plus 400 cycles from the trigger fall
    assign span_d = (trig_q && !tr_n) ? 9'h001 :
                    (span_q != 9'h000 && span_q < 9'h191) ? span_q + 9'h001 : 9'h000;
    // Trigger history and span
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_q <= 1'b1;
            span_q <= 9'h000;
        end else begin
            trig_q <= tr_n;
            span_q <= span_d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Software sequence shapes
    sequence sw_start;
        $fell(ce_n) && oe_n && we_n && tr_n && addr == 13'h0000;
    endsequence
    sequence step(logic [12:0] a);
        ##3 ($fell(ce_n) && addr == a);
    endsequence
    sequence we_hold8;
        (we_n && !pins_o.data_pins_oe) [*8];
    endsequence
    // Assertions
    ce_setup_a: assert property ($fell(ce_n) && rc_st |->
        !$past(oe_n) && $past(we_n) && !$past(tr_n))
        else $error("chip enable recall without preset pins");
    oe_setup_a: assert property ($fell(oe_n) && rc_st |->
        !$past(ce_n) && $past(we_n) && !$past(tr_n))
        else $error("output enable recall without preset pins");
    rec_addr_a: assert property (span_q != 9'h000 |-> $stable(addr))
        else $error("address moved during recall");
    rec_wait_a: assert property (rsp_valid_o |-> span_q == 9'h000)
        else $error("recall answered too early");
    rec_init_a: assert property ($fell(tr_n) |=> rc_st)
        else $error("recall state not reached");
    rec_end_a: assert property (rc_st |=> tr_n && ce_n && oe_n)
        else $error("recall initiation not ended");
    seq_order_a: assert property (sw_start |-> step(13'h1555) ##0 step(13'h0aaa) ##0
        step(13'h1fff) ##0 step(13'h10f0) ##3 ($fell(ce_n) && addr inside {13'h0f0f, 13'h0f0e}))
        else $error("software sequence out of order");
    seq_write_a: assert property (sw_start |-> we_hold8 ##1 we_hold8)
        else $error("write during software sequence");
    addr_setup_a: assert property ($fell(ce_n) && tr_n |-> $stable(addr))
        else $error("address not set before select");
    addr_hold_a: assert property ($rose(ce_n) |-> $stable(addr))
        else $error("address not held to deselect");
    sel_pulse_a: assert property ($fell(ce_n) && oe_n && we_n && tr_n |=> $rose(ce_n))
        else $error("sequence select pulse wrong");
endmodule

bind nvsrc_ctrl nvsrc_ctrl_properties #(.STORE_WAIT_CYC(STORE_WAIT_CYC)) u_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .pins_o(pins_o),
    .data_pins_i(data_pins_i));

// ==== nvsrc_defines.svh ====
// Purpose: Named widths, pin addresses and timing counts for the nvsram controller
// Assumes: 20 MHz system clock, slow speed grade figures cover the fast grade
// Notes:   Times keep their printed unit; cycle counts derive from the clock period
`ifndef NVSRC_DEFINES_SVH
`define NVSRC_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Widths
`define NVSRC_ADDR_W            13
`define NVSRC_DATA_W            8
`define NVSRC_CNT_W             18
`define NVSRC_IDX_W             3

////////////////////////////////////////////////////////////////////////////////
// Software sequence addresses, in order
`define NVSRC_SEQ_ADDR0         13'h0000
`define NVSRC_SEQ_ADDR1         13'h1555
`define NVSRC_SEQ_ADDR2         13'h0aaa
`define NVSRC_SEQ_ADDR3         13'h1fff
`define NVSRC_SEQ_ADDR4         13'h10f0
`define NVSRC_SEQ_STORE_ADDR    13'h0f0f
`define NVSRC_SEQ_RECALL_ADDR   13'h0f0e
`define NVSRC_SEQ_IDX1          3'h1
`define NVSRC_SEQ_IDX2          3'h2
`define NVSRC_SEQ_IDX3          3'h3
`define NVSRC_SEQ_IDX4          3'h4
`define NVSRC_SEQ_LAST          3'h5
`define NVSRC_SEQ_FIRST         3'h0

////////////////////////////////////////////////////////////////////////////////
// Times in their own units
`define NVSRC_CLK_PERIOD_NS     50
`define NVSRC_SELECT_PULSE_NS   45
`define NVSRC_RECALL_INIT_NS    25
`define NVSRC_RECALL_DUR_US     20
`define NVSRC_STORE_DUR_MS      10
`define NVSRC_SYNC_STAGES       2
`define NVSRC_PIN_LAG           1

////////////////////////////////////////////////////////////////////////////////
// Cycle counts, least times rounded up
`define NVSRC_SELECT_CYC      ((`NVSRC_SELECT_PULSE_NS + `NVSRC_CLK_PERIOD_NS - 1) / `NVSRC_CLK_PERIOD_NS)
`define NVSRC_RECALL_INIT_CYC ((`NVSRC_RECALL_INIT_NS + `NVSRC_CLK_PERIOD_NS - 1) / `NVSRC_CLK_PERIOD_NS)
`define NVSRC_RECALL_CYC      ((`NVSRC_RECALL_DUR_US * 1000 + `NVSRC_CLK_PERIOD_NS - 1) / `NVSRC_CLK_PERIOD_NS)
`define NVSRC_STORE_CYC       ((`NVSRC_STORE_DUR_MS * 1000000 + `NVSRC_CLK_PERIOD_NS - 1) / `NVSRC_CLK_PERIOD_NS)
`define NVSRC_READ_CYC        (`NVSRC_SELECT_CYC + `NVSRC_SYNC_STAGES + `NVSRC_PIN_LAG)

`endif

// ==== nvsrc_mem_model.sv ====
// Purpose: Behavioural 8K x 8 nvsram on the far side of the pins
// Assumes: Pins arrive as the controller's registered struct
// Notes:   Released data lines show the inverse of the last driven byte
`timescale 1ns/1ps
`include "nvsrc_defines.svh"

module nvsrc_mem_model
    import nvsrc_pkg::*;
#(
    parameter int RECALL_NS = 20000,
    parameter int STORE_NS  = 1000
) (
    input  wire nvsrc_pkg::nvsrc_pins_t pins_i,
    output logic [7:0]                  dq_o,
    output int                          n_store_o,
    output int                          n_recall_o,
    output int                          n_viol_o
);
    logic [7:0]  mem [0:8191];
    logic [7:0]  shadow [0:8191];
    logic [12:0] seq [0:4];
    logic [7:0]  held = 8'h00;
    logic        busy = 1'b0;
    logic        rec_busy = 1'b0;
    logic        armed = 1'b0;
    logic        in_rc = 1'b0;
    int          idx = 0;
    realtime     t_in = 0;
    wire logic        ce_n = pins_i.chip_enable_n;
    wire logic        we_n = pins_i.write_enable_n;
    wire logic        oe_n = pins_i.output_enable_n;
    wire logic        tr_n = pins_i.nonvolatile_trigger_n;
    wire logic [12:0] a    = pins_i.address_pins;

    // Transfer run, inputs ignored until done
    // bounded transfer
    task automatic run(input logic st);
        busy = 1'b1;
        rec_busy = !st;
        if (!st) begin
            for (int i = 0; i < 8192; i++) mem[i] = shadow[i];
            n_recall_o++;
            #(RECALL_NS);
        end else begin
            n_store_o++;
            #(STORE_NS);
            for (int i = 0; i < 8192; i++) shadow[i] = mem[i];
        end
        busy = 1'b0;
        rec_busy = 1'b0;
    endtask

    // Power-up contents
    initial begin
        n_store_o = 0;
        n_recall_o = 0;
        n_viol_o = 0;
        seq = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
        for (int i = 0; i < 8192; i++) shadow[i] = i[7:0] ^ 8'h5a;
        for (int i = 0; i < 8192; i++) mem[i] = shadow[i];
    end

    always @(pins_i or busy) begin
        if (!busy && !ce_n && we_n && !oe_n && tr_n) begin
            held = mem[a];
            dq_o = held;
        end else begin
            dq_o = ~held;
        end
    end

    always @(pins_i) begin
        if (!busy && !ce_n && !we_n && tr_n) mem[a] = pins_i.data_pins;
    end

    always @(negedge tr_n) armed = 1'b1;

    always @(pins_i) begin
        if (rc_now() && !in_rc) t_in = $realtime;
        if (!rc_now() && in_rc && armed && !busy && $realtime - t_in >= 25.0) begin
            in_rc = 1'b0;
            armed = 1'b0;
            run(1'b0);
        end
        in_rc = rc_now();
    end

    function automatic logic rc_now();
        return !ce_n && !oe_n && we_n && !tr_n;
    endfunction

    always @(negedge ce_n) begin
        if (busy) begin
        end else if (!we_n || !tr_n) begin
            idx = 0;
        end else if (idx == 5 && (a == 13'h0f0f || a == 13'h0f0e)) begin
            idx = 0;
            run(a == 13'h0f0f);
        end else if (idx < 5 && a == seq[idx]) begin
            idx++;
        end else begin
            idx = (a == 13'h0000) ? 1 : 0;
        end
    end

    always @(a) begin
        if (rec_busy) n_viol_o++;
    end
endmodule

// ==== nvsrc_pkg.sv ====
// Purpose: Types shared by the nvsram controller files
// Assumes: nvsrc_defines.svh supplies the widths
// Notes:   State codes are one-hot
`include "nvsrc_defines.svh"

package nvsrc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Commands from the user side
    typedef enum logic [2:0] {
        NVSRC_OP_READ       = 3'h0,
        NVSRC_OP_WRITE      = 3'h1,
        NVSRC_OP_RECALL_CE  = 3'h2,
        NVSRC_OP_RECALL_OE  = 3'h3,
        NVSRC_OP_SW_STORE   = 3'h4,
        NVSRC_OP_SW_RECALL  = 3'h5
    } nvsrc_op_t;

    typedef struct packed {
        nvsrc_op_t                  op;
        logic [`NVSRC_ADDR_W-1:0]   addr;
        logic [`NVSRC_DATA_W-1:0]   wdata;
    } nvsrc_cmd_t;

    ////////////////////////////////////////////////////////////////////////////
    // Memory pins driven by the controller
    typedef struct packed {
        logic                       chip_enable_n;
        logic                       write_enable_n;
        logic                       output_enable_n;
        logic                       nonvolatile_trigger_n;
        logic [`NVSRC_ADDR_W-1:0]   address_pins;
        logic [`NVSRC_DATA_W-1:0]   data_pins;
        logic                       data_pins_oe;
    } nvsrc_pins_t;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states
    typedef enum logic [4:0] {
        NVSRC_ST_IDLE    = 5'h01,
        NVSRC_ST_SETUP   = 5'h02,
        NVSRC_ST_SELECT  = 5'h04,
        NVSRC_ST_RELEASE = 5'h08,
        NVSRC_ST_WAIT    = 5'h10
    } nvsrc_state_t;

endpackage

// ==== nvsrc_timer.sv ====
// Purpose: Down counter timing pin phases and non-volatile waits
// Assumes: Load values are one or more
// Notes:   done_o is high in the last of the loaded number of cycles
`timescale 1ns/1ps

module nvsrc_timer #(
    parameter int W = 18
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              done_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Next count: load minus one, else count down to zero
    assign cnt_d = load_i ? W'(value_i - W'(1)) :
                   (cnt_q != '0) ? W'(cnt_q - W'(1)) : cnt_q;
    assign done_o = (cnt_q == '0);

    // Count register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the nvsram controller
// Assumes: Memory model stands on the far side of the pins
// Notes:   Store wait shortened to 20 cycles
`timescale 1ns/1ps
`include "nvsrc_defines.svh"

module testbench;
    import nvsrc_pkg::*;
    localparam logic [17:0] STORE_CYC = 18'h00014;
    localparam int          STORE_LAT = 18 + 20;
    localparam nvsrc_pins_t IDLE_PINS = '{1'b1, 1'b1, 1'b1, 1'b1, 13'h0000, 8'h00, 1'b0};
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        cmd_valid_i = 1'b0;
    nvsrc_cmd_t  cmd_i = '0;
    logic        cmd_ready_o;
    logic        rsp_valid_o;
    logic [7:0]  rsp_rdata_o;
    nvsrc_pins_t pins_o;
    logic [7:0]  data_pins_i;
    logic [7:0]  dev_dq;
    int          n_store, n_recall, n_viol;
    int          fails = 0;
    int          samples_checked = 0;

    // Clock and data wire
    always #25 clk_i = ~clk_i;
    assign data_pins_i = pins_o.data_pins_oe ? pins_o.data_pins : dev_dq;

    nvsrc_ctrl #(.STORE_WAIT_CYC(STORE_CYC)) u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .cmd_i(cmd_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .pins_o(pins_o), .data_pins_i(data_pins_i));
    nvsrc_mem_model #(.RECALL_NS(20000), .STORE_NS(1000)) u_mem (
        .pins_i(pins_o), .dq_o(dev_dq), .n_store_o(n_store), .n_recall_o(n_recall),
        .n_viol_o(n_viol));

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // One command, latency compared
    task automatic do_cmd(input nvsrc_op_t op, input logic [12:0] a, input logic [7:0] d,
                          input int lat);
        int   n;
        logic ok;
        @(posedge clk_i);
        #1 cmd_valid_i = 1'b1;
        cmd_i = '{op, a, d};
        do begin
            @(negedge clk_i);
            ok = cmd_ready_o;
            @(posedge clk_i);
        end while (ok !== 1'b1);
        #1 cmd_valid_i = 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (rsp_valid_o !== 1'b1 && n < 1000);
        check(n == lat, "answer latency");
    endtask

    task automatic test_reset();
        repeat (2) begin
            check(pins_o === IDLE_PINS, "idle pins");
            check(cmd_ready_o === 1'b1 && rsp_valid_o === 1'b0, "idle handshake");
            @(posedge clk_i);
            #1;
        end
        $display("test_reset done");
    endtask

    task automatic test_rw();
        logic [12:0] ad [3] = '{13'h0000, 13'h1fff, 13'h0a5a};
        logic [7:0]  dv [3] = '{8'hff, 8'h01, 8'h96};
        for (int k = 0; k < 3; k++) do_cmd(NVSRC_OP_WRITE, ad[k], dv[k], 3);
        for (int k = 0; k < 3; k++) begin
            do_cmd(NVSRC_OP_READ, ad[k], 8'h00, 6);
            check(rsp_rdata_o === dv[k], "read back");
        end
        $display("test_rw done");
    endtask

    task automatic test_sw();
        do_cmd(NVSRC_OP_WRITE, 13'h0123, 8'ha5, 3);
        do_cmd(NVSRC_OP_SW_STORE, 13'h0000, 8'h00, STORE_LAT);
        check(n_store == 1, "store count");
        do_cmd(NVSRC_OP_WRITE, 13'h0123, 8'h3c, 3);
        do_cmd(NVSRC_OP_READ, 13'h0123, 8'h00, 6);
        check(rsp_rdata_o === 8'h3c, "write after store");
        do_cmd(NVSRC_OP_SW_RECALL, 13'h0000, 8'h00, 418);
        do_cmd(NVSRC_OP_READ, 13'h0123, 8'h00, 6);
        check(rsp_rdata_o === 8'ha5 && n_recall == 1, "software recall");
        $display("test_sw done");
    endtask

    task automatic test_pin();
        nvsrc_op_t ops [2] = '{NVSRC_OP_RECALL_CE, NVSRC_OP_RECALL_OE};
        for (int k = 0; k < 2; k++) begin
            do_cmd(NVSRC_OP_WRITE, 13'h0123, 8'h66, 3);
            do_cmd(ops[k], 13'h0000, 8'h00, 403);
            do_cmd(NVSRC_OP_READ, 13'h0123, 8'h00, 6);
            check(rsp_rdata_o === 8'ha5, "pin recall data");
        end
        check(n_recall == 3 && n_viol == 0, "recall count and hold");
        $display("test_pin done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog, about three times the expected run
    initial begin
        #200000;
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        test_reset();
        test_rw();
        test_sw();
        test_pin();
        close_out();
    end
endmodule
